// ### rtl/epm_pkg.sv
package epm_pkg;
    // ************************************************************
    // Port geometry and reset values
    // ************************************************************
    localparam int EPM_WIDTH = 8;
    localparam int EPM_ANA_PINS = 6;
    localparam logic [7:0] EPM_DIR_RST = 8'hff;
    localparam logic [7:0] EPM_LAT_RST = 8'h00;
    localparam logic [7:0] EPM_ANSEL_RST = 8'hff;
    // First analog channel reached by pin 0
    localparam int EPM_ANA_CH_FIRST = 20;
    localparam int EPM_ANA_CH_LAST = 25;
    // Pin positions of the peripheral functions
    localparam int EPM_PIN_SCLK = 0;
    localparam int EPM_PIN_CCP = 1;
    localparam int EPM_PIN_PWM2_B = 2;
    localparam int EPM_PIN_PWM2_C = 3;
    localparam int EPM_PIN_PWM2_D = 4;
    localparam int EPM_PIN_PWM1_B = 5;

    // Owner of a pin's output driver, highest priority first
    typedef enum logic [2:0] {
        EPM_SRC_PERIPH_A,
        EPM_SRC_PERIPH_B,
        EPM_SRC_LATCH
    } epm_src_e;
endpackage

// ### rtl/epm_mux_if.sv
`timescale 1ns/1ps
interface epm_mux_if;
    import epm_pkg::*;
    // Peripheral output values and enables per pin, two ranks
    logic [7:0] hi_val;
    logic [7:0] hi_en;
    logic [7:0] lo_val;
    logic [7:0] lo_en;
    modport src (output hi_val, hi_en, lo_val, lo_en);
    modport dst (input hi_val, hi_en, lo_val, lo_en);
endinterface

// ### rtl/epm_sync.sv
`timescale 1ns/1ps
module epm_sync
    import epm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk_in, // Core clock
    input wire logic reset_n_in, // Sync reset, low active
    input wire logic clk_en_in, // Clock enable
    input wire logic [WIDTH-1:0] d_in, // Asynchronous input
    output logic [WIDTH-1:0] q_out // Synchronised output
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    // Two-stage synchroniser, first stage read only by second
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            meta_r <= '0;
            q_r <= '0;
        end else if (clk_en_in) begin
            meta_r <= d_in;
            q_r <= meta_r;
        end
    end

    assign q_out = q_r;
endmodule

// ### rtl/epm_prio.sv
`timescale 1ns/1ps
module epm_prio
    import epm_pkg::*;
(
    epm_mux_if.dst mux, // Peripheral outputs
    input wire logic [7:0] lat_in, // Output latch
    output logic [7:0] val_out // Selected pin value
);
    // ************************************************************
    // Fixed output priority per pin
    // ************************************************************
    function automatic epm_src_e pick(input logic hi, input logic lo);
        if (hi) begin
            return EPM_SRC_PERIPH_A;
        end else if (lo) begin
            return EPM_SRC_PERIPH_B;
        end
        return EPM_SRC_LATCH;
    endfunction

    genvar g;
    generate
        for (g = 0; g < EPM_WIDTH; g++) begin : g_pin
            epm_src_e sel;
            // R6: higher priority wins
            assign sel = pick(mux.hi_en[g], mux.lo_en[g]);
            assign val_out[g] = (sel == EPM_SRC_PERIPH_A) ? mux.hi_val[g] :
                                (sel == EPM_SRC_PERIPH_B) ? mux.lo_val[g] :
                                lat_in[g];
        end
    endgenerate
endmodule

// ### rtl/epm_port.sv
`timescale 1ns/1ps
// What this block does
// R1: Eight pins, each input or output alone
// R2: Direction one turns the driver off
// R3: Direction zero drives latch onto pin
// R4: Latch readable; read-modify-write uses latch
// R5: Reset makes every pin analog
// R6: Higher priority peripheral owns the pin
// R7: Digital outputs still drive analog pins
// R8: Pins 0-5 reach analog channels 20-25
// R9: Analog select blocks digital read path
// R10: Latch drives output whatever analog setting
// R11: Pin 0 carries serial clock in/out
// R12: Pin 1 compare/PWM, capture, serial data
// R13: Pin 2 outputs PWM unit 2 b
// R14: Pin 3 outputs PWM2 c, client select
// R15: Pin 4 outputs PWM2 d, serial data
// R16: Pin 5 outputs PWM unit 1 b
// R17: Write sets latch; read returns pins
module epm_port
    import epm_pkg::*;
(
    input wire logic ref_clk_in, // Core clock, 250 MHz
    input wire logic reset_n_in, // Sync power-on reset, low active
    input wire logic clk_en_in, // Freezes all state when low
    // Software access
    input wire logic lat_wr_in, // Write output latch
    input wire logic pin_wr_in, // Write via pin level register
    input wire logic dir_wr_in, // Write direction register
    input wire logic ansel_wr_in, // Write analog select register
    input wire logic [7:0] wdata_in, // Write data
    output logic [7:0] output_latch_reg_out, // Latch read back
    output logic [7:0] pin_level_reg_out, // Sampled pin levels
    output logic [7:0] direction_reg_out, // Direction read back
    output logic [7:0] analog_select_reg_out, // Analog select read back
    // Peripheral outputs
    input wire logic serial2_en_in, // Second serial port enabled
    input wire logic serial2_i2c_mode_in, // 1 = I2C, 0 = SPI
    input wire logic serial2_clk_o_in, // Serial clock to drive
    input wire logic serial2_spi_data_out_in, // SPI data out
    input wire logic serial2_i2c_data_o_in, // I2C data to drive
    input wire logic capture_compare_ch4_en_in, // Compare/PWM output enable
    input wire logic capture_compare_ch4_in, // Compare/PWM value
    input wire logic [3:0] pwm_steer_en_in, // Steering enables, pins 2..5
    input wire logic [3:0] pwm_val_in, // Steering values, pins 2..5
    // Pins
    input wire logic [7:0] pin_in, // Pin levels
    output logic [7:0] pin_out, // Pin drive value
    output logic [7:0] pin_oe_out, // High while driving pin
    // Peripheral inputs
    output logic serial2_clock_in_out, // Clock seen on pin 0
    output logic serial2_data_in_out, // SPI/I2C data seen on pin 1
    output logic capture_ch4_in_out, // Capture input from pin 1
    output logic serial2_client_select_out, // Client select, pin 3
    output logic [5:0] analog_chan_en_out // Channels 20..25 live
);
    // ************************************************************
    // Software-visible registers
    // ************************************************************
    logic [7:0] lat_r;
    logic [7:0] lat_nxt;
    logic [7:0] dir_r;
    logic [7:0] ansel_r;
    logic [7:0] pin_sync;
    logic [7:0] pin_mux_val;
    logic [7:0] pin_out_r;
    logic [7:0] pin_oe_r;
    logic [7:0] level_r;
    logic [7:0] dig_in;
    logic [7:0] oe_nxt;
    logic sclk_in_r;
    logic sdata_in_r;
    logic cap_in_r;
    logic csel_r;
    logic [5:0] ana_r;

    epm_mux_if mux ();

    // R17: pin register write lands in latch
    assign lat_nxt = (lat_wr_in || pin_wr_in) ? wdata_in : lat_r;

    // R4: latch keeps written value
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            lat_r <= EPM_LAT_RST;
        end else if (clk_en_in) begin
            lat_r <= lat_nxt;
        end
    end

    // R1: one direction bit per pin
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            dir_r <= EPM_DIR_RST;
        end else if (clk_en_in && dir_wr_in) begin
            dir_r <= wdata_in;
        end
    end

    // R5: analog after reset
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ansel_r <= EPM_ANSEL_RST;
        end else if (clk_en_in && ansel_wr_in) begin
            ansel_r <= wdata_in;
        end
    end

    // ************************************************************
    // Peripheral output ranking
    // ************************************************************
    // R11: serial clock out on pin 0
    assign mux.hi_en[EPM_PIN_SCLK] = serial2_en_in;
    assign mux.hi_val[EPM_PIN_SCLK] = serial2_clk_o_in;
    assign mux.lo_en[EPM_PIN_SCLK] = 1'b0;
    assign mux.lo_val[EPM_PIN_SCLK] = 1'b0;
    // R12: compare output over I2C data
    assign mux.hi_en[EPM_PIN_CCP] = capture_compare_ch4_en_in;
    assign mux.hi_val[EPM_PIN_CCP] = capture_compare_ch4_in;
    assign mux.lo_en[EPM_PIN_CCP] = serial2_en_in & serial2_i2c_mode_in;
    assign mux.lo_val[EPM_PIN_CCP] = serial2_i2c_data_o_in;
    // R13: PWM unit 2 b on pin 2
    assign mux.hi_en[EPM_PIN_PWM2_B] = pwm_steer_en_in[0];
    assign mux.hi_val[EPM_PIN_PWM2_B] = pwm_val_in[0];
    assign mux.lo_en[EPM_PIN_PWM2_B] = 1'b0;
    assign mux.lo_val[EPM_PIN_PWM2_B] = 1'b0;
    // R14: PWM unit 2 c on pin 3
    assign mux.hi_en[EPM_PIN_PWM2_C] = pwm_steer_en_in[1];
    assign mux.hi_val[EPM_PIN_PWM2_C] = pwm_val_in[1];
    assign mux.lo_en[EPM_PIN_PWM2_C] = 1'b0;
    assign mux.lo_val[EPM_PIN_PWM2_C] = 1'b0;
    // R15: PWM unit 2 d over SPI data out
    assign mux.hi_en[EPM_PIN_PWM2_D] = pwm_steer_en_in[2];
    assign mux.hi_val[EPM_PIN_PWM2_D] = pwm_val_in[2];
    assign mux.lo_en[EPM_PIN_PWM2_D] = serial2_en_in & ~serial2_i2c_mode_in;
    assign mux.lo_val[EPM_PIN_PWM2_D] = serial2_spi_data_out_in;
    // R16: PWM unit 1 b on pin 5
    assign mux.hi_en[EPM_PIN_PWM1_B] = pwm_steer_en_in[3];
    assign mux.hi_val[EPM_PIN_PWM1_B] = pwm_val_in[3];
    assign mux.lo_en[EPM_PIN_PWM1_B] = 1'b0;
    assign mux.lo_val[EPM_PIN_PWM1_B] = 1'b0;
    // Pins 6 and 7 carry only the latch here
    assign mux.hi_en[7:6] = 2'h0;
    assign mux.hi_val[7:6] = 2'h0;
    assign mux.lo_en[7:6] = 2'h0;
    assign mux.lo_val[7:6] = 2'h0;

    epm_prio u_prio (
        .mux(mux),
        .lat_in(lat_r),
        .val_out(pin_mux_val)
    );

    // ************************************************************
    // Pin drivers
    // ************************************************************
    // R2: driver off when direction is one
    // R3: driver on when direction is zero
    // R7: analog select not in enable term
    // R10: latch drives regardless of analog
    assign oe_nxt = ~dir_r;

    // Registered pin drive
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pin_out_r <= EPM_LAT_RST;
            pin_oe_r <= ~EPM_DIR_RST;
        end else if (clk_en_in) begin
            pin_out_r <= pin_mux_val;
            pin_oe_r <= oe_nxt;
        end
    end

    // ************************************************************
    // Input path
    // ************************************************************
    epm_sync #(
        .WIDTH(EPM_WIDTH)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .clk_en_in(clk_en_in),
        .d_in(pin_in),
        .q_out(pin_sync)
    );

    // R9: analog pins read as zero
    assign dig_in = pin_sync & ~ansel_r;

    // Registered read and peripheral inputs
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            level_r <= 8'h00;
            sclk_in_r <= 1'b0;
            sdata_in_r <= 1'b0;
            cap_in_r <= 1'b0;
            csel_r <= 1'b0;
            ana_r <= 6'h00;
        end else if (clk_en_in) begin
            // R17: read returns digital pin levels
            level_r <= dig_in;
            // R11: clock input when direction is one
            sclk_in_r <= dir_r[EPM_PIN_SCLK] & dig_in[EPM_PIN_SCLK];
            // R12: capture and serial data input
            sdata_in_r <= dig_in[EPM_PIN_CCP];
            cap_in_r <= dir_r[EPM_PIN_CCP] & dig_in[EPM_PIN_CCP];
            // R14: client select input on pin 3
            csel_r <= dir_r[EPM_PIN_PWM2_C] & dig_in[EPM_PIN_PWM2_C];
            // R8: analog channel live when analog mode
            ana_r <= ansel_r[EPM_ANA_PINS-1:0];
        end
    end

    assign output_latch_reg_out = lat_r;
    assign direction_reg_out = dir_r;
    assign analog_select_reg_out = ansel_r;
    assign pin_level_reg_out = level_r;
    assign pin_out = pin_out_r;
    assign pin_oe_out = pin_oe_r;
    assign serial2_clock_in_out = sclk_in_r;
    assign serial2_data_in_out = sdata_in_r;
    assign capture_ch4_in_out = cap_in_r;
    assign serial2_client_select_out = csel_r;
    assign analog_chan_en_out = ana_r;
endmodule

// ### dv/epm_port_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module epm_port_asserts
    import epm_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic lat_wr_in,
    input wire logic pin_wr_in,
    input wire logic dir_wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] output_latch_reg_out,
    input wire logic [7:0] pin_level_reg_out,
    input wire logic [7:0] direction_reg_out,
    input wire logic [7:0] analog_select_reg_out,
    input wire logic capture_compare_ch4_en_in,
    input wire logic capture_compare_ch4_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_out,
    input wire logic [5:0] analog_chan_en_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // Register writes and reset state
    property p_dir;
        dir_wr_in && clk_en_in |=> direction_reg_out == $past(wdata_in);
    endproperty
    a_dir: assert property (p_dir) else $error("dir readback");
    property p_lat;
        (lat_wr_in || pin_wr_in) && clk_en_in
            |=> output_latch_reg_out == $past(wdata_in);
    endproperty
    a_lat: assert property (p_lat) else $error("latch readback");
    property p_rst;
        disable iff (1'h0) !reset_n_in && clk_en_in
            |=> analog_select_reg_out == EPM_ANSEL_RST && pin_oe_out == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    // Pin drive follows direction, latch and pin 1 compare output
    property p_oe;
        clk_en_in |=> pin_oe_out == ~$past(direction_reg_out);
    endproperty
    a_oe: assert property (p_oe) else $error("output enable");
    property p_lat67;
        clk_en_in |=> ((pin_out ^ $past(output_latch_reg_out)) & 8'hc0) == 0;
    endproperty
    a_lat67: assert property (p_lat67) else $error("latch drive");
    property p_ccp;
        clk_en_in && capture_compare_ch4_en_in
            |=> pin_out[1] == $past(capture_compare_ch4_in);
    endproperty
    a_ccp: assert property (p_ccp) else $error("pin 1 owner");
    // Analog select effects
    property p_chan;
        (clk_en_in && $stable(analog_select_reg_out)) [*3]
            |-> analog_chan_en_out == analog_select_reg_out[5:0];
    endproperty
    a_chan: assert property (p_chan) else $error("analog channel");
    property p_read0;
        (clk_en_in && $stable(analog_select_reg_out)) [*3]
            |-> (pin_level_reg_out & analog_select_reg_out) == 8'h00;
    endproperty
    a_read0: assert property (p_read0) else $error("analog pin read");
    c_ccp: cover property (clk_en_in && capture_compare_ch4_en_in);
    c_dir: cover property (clk_en_in && dir_wr_in);
    c_pin: cover property (clk_en_in && pin_wr_in);
endmodule

bind epm_port epm_port_asserts chk_u (.*);

// ### dv/epm_board.sv
`timescale 1ns/1ps
// ****************************************
// Board pin model
// ****************************************
module epm_board (
    input wire logic ref_clk_in, // Core clock
    input wire logic [7:0] pin_out, // Port drive value
    input wire logic [7:0] pin_oe_out, // Port drive enables
    input wire logic [7:0] ext_val, // Board drive value
    input wire logic [7:0] ext_en, // Board drive enables
    output logic [7:0] pin_in // Resolved pin level
);
    logic [7:0] flt_r = 8'h55;
    // Undriven pins wander every cycle
    always @(posedge ref_clk_in) begin
        flt_r <= ~flt_r;
    end
    // Port first, board next, else floating
    assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & ext_en & ext_val)
        | (~pin_oe_out & ~ext_en & flt_r);
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
// ****************************************
// Port testbench
// ****************************************
module tb_top;
    import epm_pkg::*;
    typedef struct {logic [7:0] dir, lat, ans, ext, oe, lvl;} epm_row_s;
    logic ref_clk_in = 1'h0;
    logic reset_n_in = 1'h0;
    logic clk_en_in = 1'h1;
    logic lat_wr_in = 1'h0, pin_wr_in = 1'h0, dir_wr_in = 1'h0;
    logic ansel_wr_in = 1'h0, serial2_en_in = 1'h0, serial2_i2c_mode_in = 1'h0;
    logic serial2_clk_o_in = 1'h0, serial2_spi_data_out_in = 1'h0;
    logic serial2_i2c_data_o_in = 1'h0, capture_compare_ch4_en_in = 1'h0;
    logic capture_compare_ch4_in = 1'h0;
    logic [3:0] pwm_steer_en_in = 4'h0, pwm_val_in = 4'h0;
    logic [7:0] wdata_in = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
    logic [7:0] output_latch_reg_out, pin_level_reg_out, direction_reg_out;
    logic [7:0] analog_select_reg_out, pin_in, pin_out, pin_oe_out;
    logic serial2_clock_in_out, serial2_data_in_out, capture_ch4_in_out;
    logic serial2_client_select_out;
    logic [5:0] analog_chan_en_out;
    int num_errors = 0, n_compared = 0;
    epm_row_s rows [4] = '{
        '{8'h00, 8'ha5, 8'hff, 8'h00, 8'hff, 8'h00},
        '{8'hff, 8'h5a, 8'h00, 8'hc3, 8'h00, 8'hc3},
        '{8'h0f, 8'h33, 8'h30, 8'h96, 8'hf0, 8'h06},
        '{8'hf0, 8'hcc, 8'h0f, 8'h69, 8'h0f, 8'h60}};
    epm_port dut_u (.*);
    epm_board board_u (.*);
    // Core clock
    always #2 ref_clk_in = ~ref_clk_in;
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Strobes in order latch, pin, direction, analog
    task automatic wr(input logic [3:0] s, input logic [7:0] d);
        @(negedge ref_clk_in);
        {lat_wr_in, pin_wr_in, dir_wr_in, ansel_wr_in} = s;
        wdata_in = d;
        @(negedge ref_clk_in);
        {lat_wr_in, pin_wr_in, dir_wr_in, ansel_wr_in} = 4'h0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #4000;
        num_errors++;
        final_report();
    end
    // Main sequence
    initial begin
        idle(2);
        reset_n_in = 1'h1;
        chk("latch", output_latch_reg_out, EPM_LAT_RST);
        chk("dir", direction_reg_out, EPM_DIR_RST);
        chk("ansel", analog_select_reg_out, EPM_ANSEL_RST);
        $display("Test reset done");
        foreach (rows[i]) begin
            wr(4'h2, rows[i].dir);
            wr(4'h8, rows[i].lat);
            wr(4'h1, rows[i].ans);
            ext_val = rows[i].ext;
            ext_en = rows[i].dir;
            idle(6);
            chk("oe", pin_oe_out, rows[i].oe);
            chk("pin", pin_out, rows[i].lat);
            chk("level", pin_level_reg_out, rows[i].lvl);
            chk("chan", {2'h0, analog_chan_en_out}, {2'h0, rows[i].ans[5:0]});
        end
        $display("Test table done");
        wdata_in = 8'h00;
        dir_wr_in = 1'h1;
        @(negedge ref_clk_in);
        dir_wr_in = 1'h0;
        pin_wr_in = 1'h1;
        wdata_in = 8'h3c;
        @(negedge ref_clk_in);
        pin_wr_in = 1'h0;
        chk("dir", direction_reg_out, 8'h00);
        chk("latch", output_latch_reg_out, 8'h3c);
        clk_en_in = 1'h0;
        wr(4'h8, 8'hff);
        clk_en_in = 1'h1;
        chk("latch", output_latch_reg_out, 8'h3c);
        $display("Test writes done");
        serial2_en_in = 1'h1;
        serial2_i2c_mode_in = 1'h1;
        serial2_clk_o_in = 1'h1;
        capture_compare_ch4_en_in = 1'h1;
        capture_compare_ch4_in = 1'h1;
        pwm_steer_en_in = 4'hf;
        idle(3);
        chk("prio", pin_out, 8'h03);
        capture_compare_ch4_en_in = 1'h0;
        pwm_steer_en_in = 4'h0;
        serial2_i2c_data_o_in = 1'h1;
        idle(3);
        chk("prio", pin_out, 8'h3f);
        serial2_i2c_mode_in = 1'h0;
        serial2_spi_data_out_in = 1'h1;
        idle(3);
        chk("prio", pin_out, 8'h3d);
        pwm_steer_en_in = 4'h4;
        idle(3);
        chk("prio", pin_out, 8'h2d);
        $display("Test priority done");
        wr(4'h2, 8'hff);
        wr(4'h1, 8'h00);
        ext_en = 8'hff;
        for (int v = 0; v < 2; v++) begin
            ext_val = v[0] ? 8'h0b : 8'hf4;
            idle(5);
            chk("ins", {4'h0, serial2_clock_in_out, capture_ch4_in_out,
                serial2_data_in_out, serial2_client_select_out},
                v[0] ? 8'h0f : 8'h00);
            chk("level", pin_level_reg_out, ext_val);
        end
        $display("Test inputs done");
        wr(4'h2, 8'h00);
        idle(2);
        reset_n_in = 1'h0;
        idle(2);
        reset_n_in = 1'h1;
        chk("ansel", analog_select_reg_out, EPM_ANSEL_RST);
        chk("dir", direction_reg_out, EPM_DIR_RST);
        chk("oe", pin_oe_out, 8'h00);
        chk("pin", pin_out, EPM_LAT_RST);
        chk("latch", output_latch_reg_out, EPM_LAT_RST);
        $display("Test reset again done");
        final_report();
    end
endmodule
